//--- rtl/tpc_cfg.svh
// Named offsets, bit positions, resets and counts of the timer pair.
// Assumes a word-aligned AXI4-Lite window; byte address is four times index.
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define TPC_IX_TLO 10'h106
`define TPC_IX_THOLD 10'h108
`define TPC_IX_THI 10'h10A
`define TPC_IX_PLO 10'h10C
`define TPC_IX_PHI 10'h10E
`define TPC_IX_CLO 10'h110
`define TPC_IX_CHI 10'h112
`define TPC_IX_IFLAG 10'h120
`define TPC_IX_IEN 10'h122
`define TPC_IX_CBUF0 10'h140
`define TPC_IX_CCON0 10'h142
`define TPC_IX_CBUF1 10'h144
`define TPC_IX_CCON1 10'h146
// ----------------------------------------
// Bit positions
// ----------------------------------------
`define TPC_B_ON 15
`define TPC_B_GATE 6
`define TPC_B_PSH 5
`define TPC_B_PSL 4
`define TPC_B_WIDE 3
`define TPC_B_TCS 1
`define TPC_B_PMF 7
`define TPC_B_CTMR 7
`define TPC_B_COVF 4
`define TPC_B_CBNE 3
// ----------------------------------------
// Reset values, masks and counts
// ----------------------------------------
`define TPC_CTL_RST 16'h0000
`define TPC_PER_RST 16'hFFFF
`define TPC_TLO_WMASK 16'hA07A
`define TPC_THI_WMASK 16'hA072
`define TPC_CAP_WMASK 16'h20E7
`define TPC_PSC_T1 8'h00
`define TPC_PSC_T8 8'h07
`define TPC_PSC_T64 8'h3F
`define TPC_PSC_T256 8'hFF
`define TPC_CPS_T4 4'h3
`define TPC_CPS_T16 4'hF
`define TPC_FIFO_DEPTH 3'h4
`define TPC_RESP_OK 2'b00
`define TPC_RESP_ERR 2'b10
`endif

//--- rtl/tpc_pkg.sv
// Types shared by the timer pair with input capture.
// Assumes tpc_cfg.svh supplies the numeric constants.
package tpc_pkg;
    typedef logic [15:0] tpc_word_t;
    typedef enum logic [2:0] {
        TPC_CM_OFF = 3'h0,
        TPC_CM_BOTH = 3'h1,
        TPC_CM_FALL = 3'h2,
        TPC_CM_RISE = 3'h3,
        TPC_CM_RISE4 = 3'h4,
        TPC_CM_RISE16 = 3'h5
    } tpc_cap_mode_t;
endpackage

//--- rtl/tpc_top.sv
// Timer pair (16/32-bit) with gate, prescaler, ADC trigger and two captures.
// Assumes aclk is the instruction cycle and all pins are synchronous to it.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "tpc_cfg.svh"
module tpc_top
    import tpc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and system state
    input wire logic gate_input_pin,
    input wire logic ext_clk_pin,
    input wire logic [1:0] capture_pin,
    input wire logic cpu_sleep,
    // Events
    output logic adc_trigger,
    output logic period_irq_req
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic tpc_word_t merge(input tpc_word_t old, input tpc_word_t nw,
                                        input logic [1:0] st, input tpc_word_t msk);
        tpc_word_t m;
        m = {{8{st[1]}}, {8{st[0]}}} & msk;
        return (old & ~m) | (nw & m);
    endfunction

    function automatic logic [7:0] psc_term(input logic [1:0] sel);
        unique case (sel)
            2'b00: return `TPC_PSC_T1;
            2'b01: return `TPC_PSC_T8;
            2'b10: return `TPC_PSC_T64;
            2'b11: return `TPC_PSC_T256;
        endcase
    endfunction

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
    logic [9:0] aw_ix_r;
    logic [15:0] wd_r, rdata_r;
    logic [1:0] ws_r, bresp_r, rresp_r;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_go = aw_have_r & w_have_r & ~bvalid_r;
    wire rd_go = s_axi_arvalid & s_axi_arready;
    wire [9:0] ar_ix = s_axi_araddr[11:2];
    assign s_axi_awready = ~aw_have_r & ~bvalid_r;
    assign s_axi_wready = ~w_have_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = {16'h0000, rdata_r};

    wire wr_tlo = wr_go & (aw_ix_r == `TPC_IX_TLO);
    wire wr_thold = wr_go & (aw_ix_r == `TPC_IX_THOLD);
    wire wr_thi = wr_go & (aw_ix_r == `TPC_IX_THI);
    wire wr_plo = wr_go & (aw_ix_r == `TPC_IX_PLO);
    wire wr_phi = wr_go & (aw_ix_r == `TPC_IX_PHI);
    wire wr_clo = wr_go & (aw_ix_r == `TPC_IX_CLO);
    wire wr_chi = wr_go & (aw_ix_r == `TPC_IX_CHI);
    wire wr_iflag = wr_go & (aw_ix_r == `TPC_IX_IFLAG);
    wire wr_ien = wr_go & (aw_ix_r == `TPC_IX_IEN);
    wire [1:0] wr_ccon = {wr_go & (aw_ix_r == `TPC_IX_CCON1),
                          wr_go & (aw_ix_r == `TPC_IX_CCON0)};
    wire [1:0] rd_cbuf = {rd_go & (ar_ix == `TPC_IX_CBUF1),
                          rd_go & (ar_ix == `TPC_IX_CBUF0)};
    wire rd_tlo = rd_go & (ar_ix == `TPC_IX_TLO);
    wire wr_hit = wr_tlo | wr_thold | wr_thi | wr_plo | wr_phi | wr_clo | wr_chi
                  | wr_iflag | wr_ien | (|wr_ccon)
                  | (aw_ix_r == `TPC_IX_CBUF0) | (aw_ix_r == `TPC_IX_CBUF1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `TPC_RESP_OK;
            aw_ix_r <= 10'h000;
            wd_r <= 16'h0000;
            ws_r <= 2'b00;
        end else begin
            if (aw_take) begin
                aw_have_r <= 1'b1;
                aw_ix_r <= s_axi_awaddr[11:2];
            end
            if (w_take) begin
                w_have_r <= 1'b1;
                wd_r <= s_axi_wdata[15:0];
                ws_r <= s_axi_wstrb[1:0];
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? `TPC_RESP_OK : `TPC_RESP_ERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Timer control and period registers
    // ----------------------------------------
    tpc_word_t ctl_lo_r, ctl_hi_r, per_lo_r, per_hi_r, tmr_lo_r, tmr_hi_r, hold_r;
    logic pmf_r, pmie_r, gate_prev_r, ext_prev_r, adc_r;
    logic [7:0] psc_lo_r, psc_hi_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_lo_r <= `TPC_CTL_RST;
            ctl_hi_r <= `TPC_CTL_RST;
            per_lo_r <= `TPC_PER_RST;
            per_hi_r <= `TPC_PER_RST;
            pmie_r <= 1'b0;
        end else begin
            if (wr_clo) ctl_lo_r <= merge(ctl_lo_r, wd_r, ws_r, `TPC_TLO_WMASK);
            if (wr_chi) ctl_hi_r <= merge(ctl_hi_r, wd_r, ws_r, `TPC_THI_WMASK);
            if (wr_plo) per_lo_r <= merge(per_lo_r, wd_r, ws_r, 16'hFFFF);
            if (wr_phi) per_hi_r <= merge(per_hi_r, wd_r, ws_r, 16'hFFFF);
            if (wr_ien && ws_r[0]) pmie_r <= wd_r[`TPC_B_PMF];
        end
    end

    // ----------------------------------------
    // Clock sources, gating and prescalers
    // ----------------------------------------
    wire lo_on = ctl_lo_r[`TPC_B_ON];
    wire hi_on = ctl_hi_r[`TPC_B_ON];
    wire wide = ctl_lo_r[`TPC_B_WIDE];
    wire [1:0] ps_lo = ctl_lo_r[`TPC_B_PSH:`TPC_B_PSL];
    wire [1:0] ps_hi = ctl_hi_r[`TPC_B_PSH:`TPC_B_PSL];
    wire ext_rise = ext_clk_pin & ~ext_prev_r;
    // High timer's gate bit is never looked at
    wire gated = lo_on & ctl_lo_r[`TPC_B_GATE] & ~ctl_lo_r[`TPC_B_TCS];
    wire gate_fall = gated & gate_prev_r & ~gate_input_pin;
    // Sleep stops the instruction clock, so nothing reaches the prescalers
    wire src_lo = ~cpu_sleep & (gated ? gate_input_pin
                  : (ctl_lo_r[`TPC_B_TCS] ? ext_rise : 1'b1));
    wire src_hi = ~cpu_sleep & (ctl_hi_r[`TPC_B_TCS] ? ext_rise : 1'b1);
    wire tick_lo = lo_on & src_lo & (psc_lo_r == psc_term(ps_lo));
    wire tick_hi = ~wide & hi_on & src_hi & (psc_hi_r == psc_term(ps_hi));
    // Clear only takes while on: a halted prescaler clock cannot clear it
    wire psc_clr_lo = lo_on & (wr_tlo | wr_clo | (wide & (wr_thi | wr_chi)));
    wire psc_clr_hi = hi_on & (wr_thi | wr_chi);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psc_lo_r <= 8'h00;
            psc_hi_r <= 8'h00;
            gate_prev_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            gate_prev_r <= gate_input_pin;
            ext_prev_r <= ext_clk_pin;
            if (psc_clr_lo) psc_lo_r <= 8'h00;
            else if (lo_on && src_lo) psc_lo_r <= tick_lo ? 8'h00 : psc_lo_r + 8'h01;
            if (psc_clr_hi) psc_hi_r <= 8'h00;
            else if (~wide && hi_on && src_hi)
                psc_hi_r <= tick_hi ? 8'h00 : psc_hi_r + 8'h01;
        end
    end

    // ----------------------------------------
    // Counters, holding register, match events
    // ----------------------------------------
    wire [31:0] cnt32 = {tmr_hi_r, tmr_lo_r};
    wire m32 = cnt32 == {per_hi_r, per_lo_r};
    wire m_lo = tmr_lo_r == per_lo_r;
    wire m_hi = tmr_hi_r == per_hi_r;
    wire [31:0] cnt32_nxt = m32 ? 32'h0000_0000 : cnt32 + 32'h0000_0001;
    wire wide_match = wide & tick_lo & m32;
    wire hi_match = ~wide & tick_hi & m_hi;
    wire pmf_set = wide_match | hi_match | gate_fall;

    // No reset here: the counts power up unknown
    always_ff @(posedge aclk) begin
        if (wr_tlo) tmr_lo_r <= merge(tmr_lo_r, wd_r, ws_r, 16'hFFFF);
        else if (wide && tick_lo) tmr_lo_r <= cnt32_nxt[15:0];
        else if (!wide && tick_lo) tmr_lo_r <= m_lo ? 16'h0000 : tmr_lo_r + 16'h0001;
        if (wr_thi) tmr_hi_r <= merge(tmr_hi_r, wd_r, ws_r, 16'hFFFF);
        else if (wide && tick_lo && !wr_tlo) tmr_hi_r <= cnt32_nxt[31:16];
        else if (tick_hi) tmr_hi_r <= m_hi ? 16'h0000 : tmr_hi_r + 16'h0001;
        if (rd_tlo) hold_r <= tmr_hi_r;
        else if (wr_thold) hold_r <= merge(hold_r, wd_r, ws_r, 16'hFFFF);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pmf_r <= 1'b0;
            adc_r <= 1'b0;
        end else begin
            adc_r <= wide_match | hi_match;
            if (pmf_set) pmf_r <= 1'b1;
            else if (wr_iflag && ws_r[0]) pmf_r <= wd_r[`TPC_B_PMF];
        end
    end
    assign adc_trigger = adc_r;
    assign period_irq_req = pmf_r & pmie_r;

    // ----------------------------------------
    // Capture channels
    // ----------------------------------------
    tpc_word_t ccon_r [2];
    tpc_word_t cap_head [2];
    logic [2:0] cap_cnt [2];
    logic [1:0] cap_ovf;
    logic [1:0] cap_ev;

    for (genvar c = 0; c < 2; c++) begin : g_cap
        tpc_word_t fifo_r [4];
        logic [2:0] cnt_r;
        logic [3:0] cps_r;
        logic prev_r, ovf_r, lock_r;
        wire [2:0] mode = ccon_r[c][2:0];
        wire rise = capture_pin[c] & ~prev_r;
        wire fall = ~capture_pin[c] & prev_r;
        wire rise4 = (mode == TPC_CM_RISE4) & rise & (cps_r == `TPC_CPS_T4);
        wire rise16 = (mode == TPC_CM_RISE16) & rise & (cps_r == `TPC_CPS_T16);
        wire ev = ((mode == TPC_CM_BOTH) & (rise | fall))
                  | ((mode == TPC_CM_FALL) & fall)
                  | ((mode == TPC_CM_RISE) & rise) | rise4 | rise16;
        wire pop = rd_cbuf[c] & (cnt_r != 3'h0);
        wire take = ev & ~lock_r;
        wire push = take & (cnt_r != `TPC_FIFO_DEPTH);
        wire ovf = take & (cnt_r == `TPC_FIFO_DEPTH);
        wire [2:0] cnt_nxt = cnt_r + {2'b00, push} - {2'b00, pop};
        wire [2:0] wp = cnt_r - {2'b00, pop};
        // Timebase bit high selects the low timer
        wire tpc_word_t cap_val = ccon_r[c][`TPC_B_CTMR] ? tmr_lo_r : tmr_hi_r;

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ccon_r[c] <= `TPC_CTL_RST;
                cnt_r <= 3'h0;
                cps_r <= 4'h0;
                prev_r <= 1'b0;
                ovf_r <= 1'b0;
                lock_r <= 1'b0;
            end else begin
                prev_r <= capture_pin[c];
                if (wr_ccon[c]) ccon_r[c] <= merge(ccon_r[c], wd_r, ws_r, `TPC_CAP_WMASK);
                if (mode == TPC_CM_OFF) cps_r <= 4'h0;
                else if (rise) cps_r <= (rise4 | rise16) ? 4'h0 : cps_r + 4'h1;
                cnt_r <= cnt_nxt;
                if (ovf) ovf_r <= 1'b1;
                else if (wr_ccon[c] && ws_r[0]) ovf_r <= wd_r[`TPC_B_COVF];
                // Stays deaf until software has drained every entry
                if (ovf) lock_r <= 1'b1;
                else if (cnt_nxt == 3'h0) lock_r <= 1'b0;
            end
        end

        // Entries are not reset; reading an empty buffer is undefined
        always_ff @(posedge aclk) begin
            if (pop) begin
                for (int i = 0; i < 3; i++) fifo_r[i] <= fifo_r[i + 1];
            end
            if (push) fifo_r[wp[1:0]] <= cap_val;
        end

        assign cap_head[c] = fifo_r[0];
        assign cap_cnt[c] = cnt_r;
        assign cap_ovf[c] = ovf_r;
        assign cap_ev[c] = ev;
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    function automatic tpc_word_t ccon_view(input tpc_word_t cr, input logic ov,
                                            input logic [2:0] n);
        tpc_word_t v;
        v = cr;
        v[`TPC_B_COVF] = ov;
        v[`TPC_B_CBNE] = n != 3'h0;
        return v;
    endfunction

    wire rd_hit = (ar_ix == `TPC_IX_TLO) | (ar_ix == `TPC_IX_THOLD)
                  | (ar_ix == `TPC_IX_THI) | (ar_ix == `TPC_IX_PLO) | (ar_ix == `TPC_IX_PHI)
                  | (ar_ix == `TPC_IX_CLO) | (ar_ix == `TPC_IX_CHI)
                  | (ar_ix == `TPC_IX_IFLAG) | (ar_ix == `TPC_IX_IEN)
                  | (ar_ix == `TPC_IX_CBUF0) | (ar_ix == `TPC_IX_CCON0)
                  | (ar_ix == `TPC_IX_CBUF1) | (ar_ix == `TPC_IX_CCON1);
    wire tpc_word_t rd_mux =
        (ar_ix == `TPC_IX_TLO) ? tmr_lo_r :
        (ar_ix == `TPC_IX_THOLD) ? hold_r :
        (ar_ix == `TPC_IX_THI) ? tmr_hi_r :
        (ar_ix == `TPC_IX_PLO) ? per_lo_r :
        (ar_ix == `TPC_IX_PHI) ? per_hi_r :
        (ar_ix == `TPC_IX_CLO) ? ctl_lo_r :
        (ar_ix == `TPC_IX_CHI) ? ctl_hi_r :
        (ar_ix == `TPC_IX_IFLAG) ? {8'h00, pmf_r, 7'h00} :
        (ar_ix == `TPC_IX_IEN) ? {8'h00, pmie_r, 7'h00} :
        (ar_ix == `TPC_IX_CBUF0) ? cap_head[0] :
        (ar_ix == `TPC_IX_CCON0) ? ccon_view(ccon_r[0], cap_ovf[0], cap_cnt[0]) :
        (ar_ix == `TPC_IX_CBUF1) ? cap_head[1] :
        (ar_ix == `TPC_IX_CCON1) ? ccon_view(ccon_r[1], cap_ovf[1], cap_cnt[1]) :
        16'h0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 16'h0000;
            rresp_r <= `TPC_RESP_OK;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? `TPC_RESP_OK : `TPC_RESP_ERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wide_match;
        wide && lo_on && tick_lo && m32;
    endsequence
    sequence s_full_event;
        cap_ev[0] && !g_cap[0].lock_r && cap_cnt[0] == 3'h4 && !rd_cbuf[0];
    endsequence

    AST_GATE_IDLE: assert property (gated && !gate_input_pin |-> !tick_lo)
        else $error("gated timer advanced with gate low");
    AST_SLEEP: assert property (cpu_sleep |-> !tick_lo && !tick_hi)
        else $error("timer ticked during sleep");
    AST_PSC_HALT: assert property (!lo_on |=> $stable(psc_lo_r))
        else $error("stopped low prescaler changed");
    AST_CTL_KEEPS: assert property (wr_clo && !tick_lo |=> $stable(tmr_lo_r))
        else $error("control write moved the count");
    AST_WRAP: assert property ((s_wide_match and (!wr_tlo && !wr_thi))
        |=> cnt32 == 32'h0000_0000)
        else $error("wide count did not wrap to zero");
    AST_FLAG: assert property (s_wide_match |=> pmf_r && adc_trigger)
        else $error("wide match lost flag or trigger");
    AST_IRQ: assert property (pmf_r && pmie_r |-> period_irq_req)
        else $error("enabled flag raised no request");
    AST_HOLD: assert property (rd_tlo |=> hold_r == $past(tmr_hi_r))
        else $error("holding register missed high count");
    AST_OVF: assert property (s_full_event |=> cap_ovf[0] && cap_cnt[0] == 3'h4)
        else $error("overflow not flagged or value kept");
    AST_DEAF: assert property (g_cap[0].lock_r && !rd_cbuf[0] |=> $stable(cap_cnt[0]))
        else $error("event taken while locked");
endmodule // tpc_top

//--- verification/tpc_pin_model.sv
// Pin-side model: gate input, external clock and two capture pins.
// Assumes the bench calls its tasks; pins change just after aclk rises.
`timescale 1ns/1ps
module tpc_pin_model (
    // Clock
    input wire logic aclk,
    // Pins
    output logic gate_input_pin,
    output logic ext_clk_pin,
    output logic [1:0] capture_pin
);
    initial begin
        gate_input_pin = 1'b0;
        ext_clk_pin = 1'b0;
        capture_pin = 2'b00;
    end
    // Gate high for exactly n sampled cycles
    task automatic gate_high(input int n);
        @(posedge aclk);
        gate_input_pin <= 1'b1;
        repeat (n) @(posedge aclk);
        gate_input_pin <= 1'b0;
    endtask
    // r rising edges with falls between; last fall optional
    task automatic pulses(input int ch, input int r, input bit end_high);
        for (int i = 0; i < r; i++) begin
            @(posedge aclk);
            capture_pin[ch] <= 1'b1;
            repeat (3) @(posedge aclk);
            if (i < r - 1 || !end_high) capture_pin[ch] <= 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask
    // n external clock rises, one cycle high then one low
    task automatic ext_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            ext_clk_pin <= 1'b1;
            @(posedge aclk);
            ext_clk_pin <= 1'b0;
        end
    endtask
    task automatic cap_low(input int ch);
        @(posedge aclk);
        capture_pin[ch] <= 1'b0;
    endtask
endmodule // tpc_pin_model

//--- verification/timer_pair_with_input_capture_tb.sv
// Self-checking bench for tpc_top over AXI4-Lite with a pin model.
// Assumes the register indices of tpc_cfg.svh and a 50 MHz aclk.
`timescale 1ns/1ps
`include "tpc_cfg.svh"
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch %s expected %h seen %h", nm, e, a); end end
module timer_pair_with_input_capture_tb
    import tpc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, cpu_sleep = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, capture_pin, resp;
    logic gate_input_pin, ext_clk_pin, adc_trigger, period_irq_req;
    logic [15:0] rd;
    int n_fail = 0, total_checks = 0, cyc = 0, adc_n = 0;
    tpc_top i_tpc_top (.*);
    tpc_pin_model i_tpc_pin_model (.*);
    always #10 aclk = ~aclk;
    always @(posedge aclk) if (adc_trigger === 1'b1) adc_n++;
    // Hang guard, well above the roughly 1300 cycles the run needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            final_report();
        end
    end
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    // Leading edge keeps a ready from being lowered and raised in one step
    task automatic wr(input logic [9:0] ix, input logic [15:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {ix, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [9:0] ix);
        @(posedge aclk);
        s_axi_araddr <= {ix, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata[15:0];
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic chk_rd(input logic [9:0] ix, input logic [15:0] e, input string nm);
        rdr(ix);
        `CHK(nm, e, rd)
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        int dv[4] = '{1, 8, 64, 256};
        tpc_cap_mode_t md[5] = '{TPC_CM_FALL, TPC_CM_RISE, TPC_CM_BOTH, TPC_CM_RISE4,
            TPC_CM_RISE16};
        int rr[5] = '{4, 4, 4, 4, 16};
        bit eh[5] = '{1, 1, 1, 0, 0};
        int nn[5] = '{3, 4, 4, 1, 1};
        logic [15:0] ov[5] = '{16'h0000, 16'h0000, 16'h0010, 16'h0000, 16'h0000};
        logic [15:0] cm;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        chk_rd(`TPC_IX_CLO, 16'h0000, "low ctl");
        chk_rd(`TPC_IX_CCON0, 16'h0000, "cap1 ctl");
        chk_rd(`TPC_IX_PLO, 16'hFFFF, "period low");
        rdr(10'h130);
        `CHK("unmapped resp", 2'b10, resp)
        wr(`TPC_IX_THI, 16'h1234);
        rdr(`TPC_IX_TLO);
        chk_rd(`TPC_IX_THOLD, 16'h1234, "holding");
        $display("test reset done");
        for (int p = 0; p < 4; p++) begin
            wr(`TPC_IX_TLO, 16'h0000);
            wr(`TPC_IX_CLO, 16'h8040 | 16'(p << 4));
            i_tpc_pin_model.gate_high(2 * dv[p]);
            repeat (4) @(posedge aclk);
            chk_rd(`TPC_IX_TLO, 16'h0002, "gated count");
        end
        wr(`TPC_IX_CLO, 16'h0040);
        chk_rd(`TPC_IX_TLO, 16'h0002, "count kept");
        chk_rd(`TPC_IX_IFLAG, 16'h0080, "flag");
        `CHK("irq masked", 1'b0, period_irq_req)
        wr(`TPC_IX_IEN, 16'h0080);
        `CHK("irq on", 1'b1, period_irq_req)
        wr(`TPC_IX_IFLAG, 16'h0000);
        `CHK("irq cleared", 1'b0, period_irq_req)
        wr(`TPC_IX_CLO, 16'h8040);
        cpu_sleep <= 1'b1;
        i_tpc_pin_model.gate_high(10);
        repeat (4) @(posedge aclk);
        cpu_sleep <= 1'b0;
        chk_rd(`TPC_IX_TLO, 16'h0002, "sleep count");
        $display("test gate done");
        wr(`TPC_IX_PHI, 16'h0000);
        wr(`TPC_IX_PLO, 16'h0004);
        wr(`TPC_IX_TLO, 16'h0000);
        wr(`TPC_IX_THI, 16'h0000);
        wr(`TPC_IX_CLO, 16'h8048);
        adc_n = 0;
        i_tpc_pin_model.gate_high(23);
        repeat (4) @(posedge aclk);
        `CHK("adc pulses", 4, adc_n)
        chk_rd(`TPC_IX_TLO, 16'h0003, "wide wrap");
        wr(`TPC_IX_CLO, 16'h0000);
        wr(`TPC_IX_PHI, 16'h0002);
        wr(`TPC_IX_THI, 16'h0000);
        wr(`TPC_IX_CHI, 16'h8002);
        adc_n = 0;
        i_tpc_pin_model.ext_pulses(7);
        repeat (4) @(posedge aclk);
        `CHK("high adc pulses", 2, adc_n)
        chk_rd(`TPC_IX_THI, 16'h0001, "ext count");
        wr(`TPC_IX_CHI, 16'h0000);
        $display("test wide done");
        wr(`TPC_IX_CCON0, 16'h0083);
        for (int i = 0; i < 6; i++) begin
            wr(`TPC_IX_TLO, 16'h0100 + 16'(i));
            i_tpc_pin_model.pulses(0, 1, 1'b0);
        end
        chk_rd(`TPC_IX_CCON0, 16'h009B, "cap1 full");
        for (int i = 0; i < 4; i++) begin
            chk_rd(`TPC_IX_CBUF0, 16'h0100 + 16'(i), "cap1 data");
        end
        chk_rd(`TPC_IX_CCON0, 16'h0093, "cap1 drained");
        $display("test fifo done");
        for (int m = 0; m < 5; m++) begin
            cm = {13'h0000, md[m]};
            wr(`TPC_IX_CCON1, cm);
            i_tpc_pin_model.pulses(1, rr[m], eh[m]);
            chk_rd(`TPC_IX_CCON1, cm | 16'h0008 | ov[m], "cap2 status");
            repeat (nn[m]) rdr(`TPC_IX_CBUF1);
            chk_rd(`TPC_IX_CCON1, cm | ov[m], "cap2 drained");
            wr(`TPC_IX_CCON1, 16'h0000);
            i_tpc_pin_model.cap_low(1);
        end
        $display("test modes done");
        final_report();
    end
endmodule // timer_pair_with_input_capture_tb
